// [hw/answer_sum16.sv]
// running 16-bit byte sum used as the answer checksum
// assumes clear and add are never needed in the same cycle
`timescale 1ns/10ps
module answer_sum16 (
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    input  wire logic        clear_i,
    input  wire logic        add_i,
    input  wire logic [7:0]  byte_i,
    output logic      [15:0] sum_o
);
    typedef struct packed {
        logic [15:0] sum;    // running sum
    } sum_s;

    sum_s r;
    sum_s next_r;

    // next sum
    always_comb begin
        next_r = r;
        if (clear_i) begin
            next_r.sum = 16'h0000;
        end else if (add_i) begin
            next_r.sum = r.sum + {8'h00, byte_i};
        end
    end

    // sum register
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign sum_o = r.sum;

    AST_SUM_ADD: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (add_i && !clear_i) |=> (sum_o == $past(sum_o) + {8'h00, $past(byte_i)}))
        else $error("checksum did not add byte");
endmodule : answer_sum16

// [hw/cmd_word_assembler.sv]
// collects four host bytes into one little-endian command word
// assumes rx bytes are synchronous one-cycle strobes
`timescale 1ns/10ps
module cmd_word_assembler (
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    input  wire logic [7:0]  rx_byte_i,
    input  wire logic        rx_valid_i,
    input  wire logic        accept_i,
    output logic      [31:0] cmd_o,
    output logic             cmd_valid_o
);
    typedef struct packed {
        logic [31:0] word;   // shift register, first byte lowest
        logic [1:0]  cnt;    // bytes collected so far
        logic        done;   // word complete pulse
    } asm_s;

    asm_s r;
    asm_s next_r;

    // next state
    always_comb begin
        next_r      = r;
        next_r.done = 1'b0;
        // bytes arriving while busy are dropped and restart the word
        if (!accept_i) begin
            next_r.cnt = 2'h0;
        end else if (rx_valid_i) begin
            next_r.word = {rx_byte_i, r.word[31:8]};
            next_r.cnt  = r.cnt + 2'h1;
            next_r.done = (r.cnt == 2'h3);
        end
    end

    // state register
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign cmd_o       = r.word;
    assign cmd_valid_o = r.done;

    AST_CMD_LE: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (accept_i && rx_valid_i && r.cnt == 2'h3) |=> (cmd_valid_o && cmd_o[31:24] == $past(rx_byte_i)))
        else $error("command word not little-endian");
endmodule : cmd_word_assembler

// [hw/encoder_info_query_commands.sv]
// encoder identity and ratings query handler with avalon-mm registers
// assumes a byte host link with ready, and a byte encoder memory port
`timescale 1ns/10ps
`include "enc_query_params.svh"
module encoder_info_query_commands (
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    // avalon-mm slave
    input  wire logic [3:0]  address_i,
    input  wire logic        read_i,
    input  wire logic        write_i,
    input  wire logic [31:0] writedata_i,
    input  wire logic [3:0]  byteenable_i,
    output logic      [31:0] readdata_o,
    output logic             waitrequest_o,
    // host byte link
    input  wire logic [7:0]  rx_byte_i,
    input  wire logic        rx_valid_i,
    output logic      [7:0]  tx_byte_o,
    output logic             tx_valid_o,
    input  wire logic        tx_ready_i,
    // encoder memory read port
    output logic      [15:0] nvm_addr_o,
    output logic             nvm_rd_o,
    input  wire logic [7:0]  nvm_data_i,
    input  wire logic        nvm_valid_i
);
    // assertions sample on the rising clock, off during reset
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);

    typedef struct packed {
        enc_query_pkg::seq_state_e  st;        // sequencer state
        enc_query_pkg::query_kind_e kind;      // query in progress
        logic [31:0]                cmd;       // echoed code
        logic [6:0]                 idx;       // byte index in answer
        logic [7:0]                 tx_byte;   // byte on the link
        logic                       tx_valid;  // byte offered
        logic                       nvm_rd;    // memory read strobe
        logic [15:0]                nvm_addr;  // memory address
        logic                       ctrl_en;   // handler enabled
        logic [15:0]                id_base;   // identity record base
        logic [15:0]                rat_base;  // ratings record base
        logic [7:0]                 unk_cnt;   // unknown codes seen
        logic [31:0]                last_cmd;  // last code received
        logic                       wait_req;  // bus wait flag
        logic [31:0]                rdata;     // bus read data
    } top_s;

    top_s r;
    top_s next_r;

    logic [31:0] cmd_word;     // assembled request
    logic        cmd_valid;    // request complete pulse
    logic        accept;       // handler ready for a request
    logic        sum_clear;    // restart checksum
    logic        sum_add;      // add byte to checksum
    logic [15:0] sum;          // checksum so far
    logic [6:0]  len;          // answer length of current kind
    logic [6:0]  nvm_end;      // end of memory span
    logic [15:0] base;         // memory base of current kind
    logic        flag_byte;    // current byte is in flag word
    logic [7:0]  flag_mask;    // defined flag bits of that byte

    // requests only while idle and enabled
    assign accept = r.ctrl_en && (r.st == enc_query_pkg::ST_IDLE);

    // request byte collector
    cmd_word_assembler u_asm (
        .clk_i       (clk_i),
        .nrst_i      (nrst_i),
        .rx_byte_i   (rx_byte_i),
        .rx_valid_i  (rx_valid_i),
        .accept_i    (accept),
        .cmd_o       (cmd_word),
        .cmd_valid_o (cmd_valid)
    );

    // checksum accumulator
    answer_sum16 u_sum (
        .clk_i   (clk_i),
        .nrst_i  (nrst_i),
        .clear_i (sum_clear),
        .add_i   (sum_add),
        .byte_i  (r.tx_byte),
        .sum_o   (sum)
    );

    // per-kind layout selection
    always_comb begin
        if (r.kind == enc_query_pkg::KIND_ID) begin
            len     = `ID_LEN;
            nvm_end = `ID_NVM_END;
            base    = r.id_base;
        end else begin
            len     = `RAT_LEN;
            nvm_end = `RAT_NVM_END;
            base    = r.rat_base;
        end
    end

    // flag word masking, only defined capability bits pass
    always_comb begin
        flag_byte = (r.kind == enc_query_pkg::KIND_RAT) && (r.idx >= `RAT_FLAG_FIRST)
                    && (r.idx < `RAT_NVM_END);
        flag_mask = 8'((`DIFF_OUTPUT_FLAG | `PUSH_PULL_FLAG | `INDEX_PRESENT_FLAG
                       | `REV_SENSOR_PRESENT_FLAG | `REV_SENSOR_HIGH_ACTIVE_FLAG)
                       >> {r.idx[1:0], 3'h0});
    end

    // next state of bus, registers and sequencer
    always_comb begin
        logic [6:0] nidx;
        nidx          = r.idx + 7'h01;
        next_r        = r;
        next_r.nvm_rd = 1'b0;
        sum_clear     = 1'b0;
        sum_add       = 1'b0;

        // bus: one wait cycle, then the access completes
        if ((read_i || write_i) && r.wait_req) begin
            next_r.wait_req = 1'b0;
            next_r.rdata    = 32'h0000_0000;
            if (address_i == `REG_CTRL) begin
                next_r.rdata[0] = r.ctrl_en;
            end else if (address_i == `REG_STATUS) begin
                next_r.rdata[`STAT_BUSY]                 = !accept;
                next_r.rdata[`STAT_UNK_LO +: 8]          = r.unk_cnt;
            end else if (address_i == `REG_LAST_CMD) begin
                next_r.rdata = r.last_cmd;
            end else if (address_i == `REG_NVM_BASE) begin
                next_r.rdata = {r.rat_base, r.id_base};
            end
        end else if ((read_i || write_i) && !r.wait_req) begin
            // access taken at this edge
            next_r.wait_req = 1'b1;
            if (write_i && address_i == `REG_CTRL && byteenable_i[0]) begin
                next_r.ctrl_en = writedata_i[0];
            end else if (write_i && address_i == `REG_NVM_BASE) begin
                // byte lanes of the two base fields
                if (byteenable_i[0]) next_r.id_base[7:0]   = writedata_i[7:0];
                if (byteenable_i[1]) next_r.id_base[15:8]  = writedata_i[15:8];
                if (byteenable_i[2]) next_r.rat_base[7:0]  = writedata_i[23:16];
                if (byteenable_i[3]) next_r.rat_base[15:8] = writedata_i[31:24];
            end
        end

        // answer sequencer
        case (r.st)
            enc_query_pkg::ST_IDLE: begin
                if (cmd_valid) begin
                    next_r.last_cmd = cmd_word;
                    next_r.cmd      = cmd_word;
                    next_r.idx      = 7'h00;
                    next_r.tx_byte  = cmd_word[7:0];
                    sum_clear       = 1'b1;
                    if (cmd_word == `ID_CODE) begin
                        next_r.kind     = enc_query_pkg::KIND_ID;
                        next_r.tx_valid = 1'b1;
                        next_r.st       = enc_query_pkg::ST_SEND;
                    end else if (cmd_word == `RAT_CODE) begin
                        next_r.kind     = enc_query_pkg::KIND_RAT;
                        next_r.tx_valid = 1'b1;
                        next_r.st       = enc_query_pkg::ST_SEND;
                    end else begin
                        // unknown code, no answer
                        next_r.unk_cnt = r.unk_cnt + 8'h01;
                    end
                end
            end
            enc_query_pkg::ST_FETCH: begin
                if (nvm_valid_i) begin
                    next_r.tx_byte  = flag_byte ? (nvm_data_i & flag_mask) : nvm_data_i;
                    next_r.tx_valid = 1'b1;
                    next_r.st       = enc_query_pkg::ST_SEND;
                end
            end
            enc_query_pkg::ST_CRC: begin
                next_r.tx_byte  = sum[7:0];
                next_r.tx_valid = 1'b1;
                next_r.st       = enc_query_pkg::ST_SEND;
            end
            enc_query_pkg::ST_SEND: begin
                if (tx_ready_i) begin
                    sum_add = (r.idx >= `CMD_BYTES) && (r.idx < len - 7'h02);
                    if (r.idx == len - 7'h01) begin
                        next_r.tx_valid = 1'b0;
                        next_r.st       = enc_query_pkg::ST_IDLE;
                    end else begin
                        next_r.idx = nidx;
                        if (nidx < `CMD_BYTES) begin
                            next_r.tx_byte = 8'(r.cmd >> {nidx[1:0], 3'h0});
                        end else if (nidx < nvm_end) begin
                            next_r.tx_valid = 1'b0;
                            next_r.nvm_rd   = 1'b1;
                            next_r.nvm_addr = base + 16'(nidx - `CMD_BYTES);
                            next_r.st       = enc_query_pkg::ST_FETCH;
                        end else if (nidx == len - 7'h02) begin
                            // wait one cycle for the last sum update
                            next_r.tx_valid = 1'b0;
                            next_r.st       = enc_query_pkg::ST_CRC;
                        end else if (nidx == len - 7'h01) begin
                            next_r.tx_byte = sum[15:8];
                        end else begin
                            next_r.tx_byte = 8'h00;
                        end
                    end
                end
            end
            default: begin
                next_r.st = enc_query_pkg::ST_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            r          <= '0;
            r.st       <= enc_query_pkg::ST_IDLE;
            r.kind     <= enc_query_pkg::KIND_ID;
            r.ctrl_en  <= `CTRL_RST;
            r.id_base  <= `ID_BASE_RST;
            r.rat_base <= `RAT_BASE_RST;
            r.wait_req <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // outputs straight from the state register
    assign readdata_o    = r.rdata;
    assign waitrequest_o = r.wait_req;
    assign tx_byte_o     = r.tx_byte;
    assign tx_valid_o    = r.tx_valid;
    assign nvm_addr_o    = r.nvm_addr;
    assign nvm_rd_o      = r.nvm_rd;

    // request completion steps
    sequence s_id_req;
        accept && cmd_valid && cmd_word == `ID_CODE;
    endsequence
    sequence s_rat_req;
        accept && cmd_valid && cmd_word == `RAT_CODE;
    endsequence
    sequence s_bus_ack;
        !waitrequest_o ##1 waitrequest_o;
    endsequence

    AST_ID_START: assert property (s_id_req |=> (tx_valid_o && tx_byte_o == 8'(`ID_CODE)
        && r.kind == enc_query_pkg::KIND_ID))
        else $error("identity query not answered");
    AST_RAT_START: assert property (s_rat_req |=> (tx_valid_o && tx_byte_o == 8'(`RAT_CODE)
        && r.kind == enc_query_pkg::KIND_RAT))
        else $error("ratings query not answered");
    AST_ECHO: assert property ((tx_valid_o && r.idx < `CMD_BYTES)
        |-> tx_byte_o == 8'(r.cmd >> {r.idx[1:0], 3'h0}))
        else $error("echoed code byte wrong");
    AST_ANSWER_END: assert property ((tx_valid_o && tx_ready_i && r.idx == len - 7'h01)
        |=> (!tx_valid_o && r.st == enc_query_pkg::ST_IDLE))
        else $error("answer length wrong");
    AST_ID_LAST: assert property ((tx_valid_o && r.kind == enc_query_pkg::KIND_ID)
        |-> r.idx <= (`ID_LEN - 7'h01))
        else $error("identity answer too long");
    AST_NVM_PASS: assert property ((r.st == enc_query_pkg::ST_FETCH && nvm_valid_i && !flag_byte)
        |=> (tx_valid_o && tx_byte_o == $past(nvm_data_i)))
        else $error("memory byte not passed");
    AST_RESERVED: assert property ((tx_valid_o && r.idx >= nvm_end && r.idx < len - 7'h02)
        |-> tx_byte_o == 8'h00)
        else $error("reserved byte not zero");
    AST_FLAGS: assert property ((tx_valid_o && flag_byte)
        |-> (tx_byte_o & ~flag_mask) == 8'h00)
        else $error("undefined flag bit set");
    AST_CRC_LO: assert property ((tx_valid_o && r.idx == len - 7'h02)
        |-> tx_byte_o == sum[7:0])
        else $error("checksum low byte wrong");
    AST_HOLD: assert property ((tx_valid_o && !tx_ready_i)
        |=> (tx_valid_o && $stable(tx_byte_o) && $stable(r.idx)))
        else $error("link byte changed while stalled");
    AST_BUS: assert property (((read_i || write_i) && waitrequest_o) |=> s_bus_ack)
        else $error("bus answer not after one wait cycle");
endmodule : encoder_info_query_commands

// [include/enc_query_params.svh]
// constants for the encoder query command handler
// assumes byte-wide host link and byte-wide encoder memory port
`ifndef ENC_QUERY_PARAMS_SVH
`define ENC_QUERY_PARAMS_SVH

// command codes, lower-case names as little-endian words
`define ID_CODE        32'h696e6567
`define RAT_CODE       32'h736e6567

// answer lengths in bytes
`define ID_LEN         7'h46
`define RAT_LEN        7'h36
`define CMD_BYTES      7'h04

// end (exclusive) of the memory-sourced span of each answer
`define ID_NVM_END     7'h2c
`define RAT_NVM_END    7'h1c
// first byte of the capability flag word in the ratings answer
`define RAT_FLAG_FIRST 7'h18

// capability flag bits
`define DIFF_OUTPUT_FLAG            32'h0000_0001
`define PUSH_PULL_FLAG              32'h0000_0004
`define INDEX_PRESENT_FLAG          32'h0000_0010
`define REV_SENSOR_PRESENT_FLAG     32'h0000_0040
`define REV_SENSOR_HIGH_ACTIVE_FLAG 32'h0000_0100

// register byte offsets
`define REG_CTRL       4'h0
`define REG_STATUS     4'h4
`define REG_LAST_CMD   4'h8
`define REG_NVM_BASE   4'hc

// reset values
`define CTRL_RST       1'h1
`define ID_BASE_RST    16'h0000
`define RAT_BASE_RST   16'h0040

// status field positions
`define STAT_BUSY      0
`define STAT_UNK_LO    8

`endif

// [include/enc_query_pkg.sv]
// shared types of the encoder query command handler
// assumes enc_query_params.svh defines the numbers
package enc_query_pkg;

    // answer sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_FETCH,
        ST_CRC,
        ST_SEND
    } seq_state_e;

    // which query is being answered
    typedef enum logic {
        KIND_ID,
        KIND_RAT
    } query_kind_e;

endpackage : enc_query_pkg

// [verification/encoder_info_query_commands_bench.sv]
// self-checking bench of the encoder query handler
// assumes host_model as host and an inline encoder memory model
`timescale 1ns/10ps
`include "enc_query_params.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module encoder_info_query_commands_bench;
    logic        clk_i, nrst_i;            // clock and reset
    logic [3:0]  address_i, byteenable_i;  // bus request
    logic        read_i, write_i;          // bus strobes
    logic [31:0] writedata_i, readdata_o;  // bus data
    logic        waitrequest_o;            // bus answer
    logic [7:0]  rx_byte_i, tx_byte_o;     // host link bytes
    logic        rx_valid_i, tx_valid_o, tx_ready_i;
    logic [15:0] nvm_addr_o;               // memory port
    logic        nvm_rd_o, nvm_valid_i, nvm_pend;
    logic [7:0]  nvm_data_i, mem [256];    // memory contents
    logic [7:0]  nvm_ptr;                  // pending read address
    int          nvm_lat, mismatches, n_tests, cycles;
    logic        stall;                    // host stalls ready
    logic [7:0]  exp_q [$];                // expected answer bytes
    logic [31:0] rd;                       // last read word
    logic [7:0]  exp_b;                    // note taken by the monitor

    encoder_info_query_commands i_dut (
        .clk_i(clk_i), .nrst_i(nrst_i), .address_i(address_i), .read_i(read_i),
        .write_i(write_i), .writedata_i(writedata_i), .byteenable_i(byteenable_i),
        .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .rx_byte_i(rx_byte_i),
        .rx_valid_i(rx_valid_i), .tx_byte_o(tx_byte_o), .tx_valid_o(tx_valid_o),
        .tx_ready_i(tx_ready_i), .nvm_addr_o(nvm_addr_o), .nvm_rd_o(nvm_rd_o),
        .nvm_data_i(nvm_data_i), .nvm_valid_i(nvm_valid_i));
    host_model i_host (
        .clk_i(clk_i), .stall_i(stall), .rx_byte_o(rx_byte_i),
        .rx_valid_o(rx_valid_i), .tx_ready_o(tx_ready_i));

    // clock, 25 ns period
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    // encoder memory: slow random answers, changing data when idle
    always @(posedge clk_i) begin
        if (nvm_rd_o) begin
            nvm_ptr     <= nvm_addr_o[7:0];
            nvm_lat     <= $urandom_range(0, 3);
            nvm_pend    <= 1'b1;
            nvm_valid_i <= 1'b0;
            nvm_data_i  <= ~nvm_data_i;
        end else if (nvm_pend && nvm_lat == 0) begin
            nvm_valid_i <= 1'b1;
            nvm_data_i  <= mem[nvm_ptr];
            nvm_pend    <= 1'b0;
        end else begin
            nvm_lat     <= nvm_lat - 1;
            nvm_valid_i <= 1'b0;
            nvm_data_i  <= ~nvm_data_i;
        end
    end

    // monitor: every accepted answer byte against the oldest note
    always @(posedge clk_i) begin
        if (nrst_i && tx_valid_o === 1'b1 && tx_ready_i) begin
            // answer bytes in order
            // take the note once, an unexpected byte can never match
            exp_b = (exp_q.size() != 0) ? exp_q.pop_front() : ~tx_byte_o;
            `CHK(tx_byte_o, exp_b)
        end
    end

    // hang guard
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 30000) begin
            mismatches++;
            results();
        end
    end

    // one avalon access, held until waitrequest low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                       input logic [3:0] be);
        @(posedge clk_i);
        address_i    <= a;
        read_i       <= !wr;
        write_i      <= wr;
        writedata_i  <= d;
        byteenable_i <= be;
        do @(posedge clk_i); while (waitrequest_o !== 1'b0);
        rd = readdata_o;
        read_i  <= 1'b0;
        write_i <= 1'b0;
    endtask : bus

    // notes the full answer, sends the request, waits for the last byte
    task automatic query(input logic [31:0] code, input int len, input int n_mem,
                         input logic [15:0] base, input bit rat);
        logic [15:0] sum;
        logic [7:0]  b;
        sum = 16'h0000;
        for (int i = 0; i < 4; i++) exp_q.push_back(code[8*i +: 8]);
        for (int i = 0; i < len - 6; i++) begin
            b = (i < n_mem) ? mem[8'(base + 16'(i))] : 8'h00;
            if (rat && i >= 20 && i < 24) b = b & ((i == 20) ? 8'h55 : (i == 21) ? 8'h01 : 8'h00);
            sum = sum + 16'(b);
            exp_q.push_back(b);
        end
        exp_q.push_back(sum[7:0]);
        exp_q.push_back(sum[15:8]);
        i_host.send_word(code);
        while (exp_q.size() != 0) @(posedge clk_i);
        repeat (3) @(posedge clk_i);
        `CHK(tx_valid_o, 1'b0)
    endtask : query

    // closing report
    task automatic results();
        $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : results

    // main sequence
    initial begin
        {address_i, byteenable_i, read_i, write_i, writedata_i} = '0;
        {nvm_valid_i, nvm_data_i, nvm_pend, nvm_ptr, nvm_lat} = '0;
        {mismatches, n_tests, cycles, stall} = '0;
        nrst_i = 1'b0;
        void'($urandom(32'h6551));
        foreach (mem[i]) mem[i] = 8'($urandom);
        repeat (20) @(posedge clk_i);
        nrst_i <= 1'b1;
        // register reset values, unmapped and read-only places
        bus(0, `REG_CTRL, 0, 4'hf);     `CHK(rd, 32'h0000_0001)
        bus(0, `REG_NVM_BASE, 0, 4'hf); `CHK(rd, 32'h0040_0000)
        bus(1, `REG_LAST_CMD, 32'hffff_ffff, 4'hf);
        bus(0, `REG_LAST_CMD, 0, 4'hf); `CHK(rd, 32'h0000_0000)
        bus(1, 4'h1, 32'hffff_ffff, 4'hf);
        bus(0, 4'h1, 0, 4'hf);          `CHK(rd, 32'h0000_0000)
        query(`ID_CODE, 70, 40, 16'h0000, 0);
        stall = 1'b1;
        query(`RAT_CODE, 54, 24, 16'h0040, 1);
        bus(0, `REG_LAST_CMD, 0, 4'hf); `CHK(rd, 32'h736e6567)
        // unknown code: no answer, counted
        i_host.send_word(32'h1234_5678);
        repeat (10) @(posedge clk_i);
        `CHK(tx_valid_o, 1'b0)
        bus(0, `REG_STATUS, 0, 4'hf);   `CHK(rd, 32'h0000_0100)
        // disabled: request dropped
        bus(1, `REG_CTRL, 32'h0, 4'h1);
        i_host.send_word(`ID_CODE);
        repeat (100) @(posedge clk_i);
        bus(0, `REG_STATUS, 0, 4'hf);   `CHK(rd, 32'h0000_0101)
        bus(1, `REG_CTRL, 32'h1, 4'h1);
        // moved bases, lane-wise write
        bus(1, `REG_NVM_BASE, 32'h00c0_0080, 4'hf);
        bus(1, `REG_NVM_BASE, 32'hffff_0010, 4'h3);
        bus(0, `REG_NVM_BASE, 0, 4'hf); `CHK(rd, 32'h00c0_0010)
        query(`ID_CODE, 70, 40, 16'h0010, 0);
        // all ones, all zeros, random flags
        for (int p = 0; p < 3; p++) begin
            for (int k = 0; k < 4; k++) begin
                mem[8'hd4 + 8'(k)] = (p == 0) ? 8'hff : (p == 1) ? 8'h00 : 8'($urandom);
            end
            query(`RAT_CODE, 54, 24, 16'h00c0, 1);
        end
        results();
    end
endmodule : encoder_info_query_commands_bench

// [verification/host_model.sv]
// host partner: sends request words and accepts answer bytes
// assumes one clock; the answer byte is held by the device until ready
`timescale 1ns/10ps
module host_model (
    input  wire logic       clk_i,
    input  wire logic       stall_i,
    output logic      [7:0] rx_byte_o,
    output logic            rx_valid_o,
    output logic            tx_ready_o
);
    // idle link at time zero
    initial begin
        rx_byte_o  = 8'h00;
        rx_valid_o = 1'b0;
        tx_ready_o = 1'b0;
    end

    // accept side, stalling at random when asked
    always @(posedge clk_i) begin
        tx_ready_o <= stall_i ? 1'($urandom_range(0, 1)) : 1'b1;
    end

    task automatic send_word(input logic [31:0] w);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_i);
            rx_byte_o  <= w[8*i +: 8];
            rx_valid_o <= 1'b1;
        end
        @(posedge clk_i);
        // released line shows inverse of last byte
        rx_valid_o <= 1'b0;
        rx_byte_o  <= ~w[31:24];
    endtask : send_word
endmodule : host_model
